// File: rtl/vpc_pkg.sv
// Package with types and constants for the video port capture input.
package vpc_pkg;

    localparam int PIX_W      = 16;
    localparam int PIX_MSB    = 15;
    localparam int RED_HI     = 15;
    localparam int RED_LO     = 11;
    localparam int GRN_HI     = 10;
    localparam int GRN_LO     = 5;
    localparam int BLU_HI     = 4;
    localparam int BLU_LO     = 0;
    localparam int LUMA_HI    = 15;
    localparam int LUMA_LO    = 8;
    localparam int CHROMA_HI  = 7;
    localparam int CHROMA_LO  = 0;
    localparam int FIFO_DEPTH = 8;
    localparam int CLK_HZ     = 50000000;
    localparam int SCL_KHZ    = 100;
    localparam int SCL_HALF   = CLK_HZ / (SCL_KHZ * 1000 * 2);

    typedef enum logic [1:0] {
        VPC_MODE_RGB565 = 2'h0,
        VPC_MODE_YUV422 = 2'h1,
        VPC_MODE_8BIT   = 2'h2
    } vpc_mode_t;

    typedef struct packed {
        logic [15:0] data;
        logic        line_start;
        logic        field_start;
        logic        field_odd;
    } vpc_word_t;

    localparam int WORD_W = $bits(vpc_word_t);

    typedef struct packed {
        logic [4:0] red;
        logic [5:0] green;
        logic [4:0] blue;
    } vpc_rgb_t;

    typedef struct packed {
        logic [7:0] luma;
        logic [7:0] chroma;
    } vpc_yuv_t;

endpackage : vpc_pkg

// File: rtl/vpc_fifo.sv
// Dual-clock FIFO with gray-coded pointers between pixel and system domains.
module vpc_fifo #(
    parameter int WIDTH = 19,
    parameter int DEPTH = 8
) (
    // Write side, pixel clock.
    input  wire logic             wclk_in,
    input  wire logic             wrst_in,
    input  wire logic             wvalid_in,
    output logic                  wready_out,
    input  wire logic [WIDTH-1:0] wdata_in,
    // Read side, system clock.
    input  wire logic             rclk_in,
    input  wire logic             rrst_in,
    output logic                  rvalid_out,
    input  wire logic             rready_in,
    output logic [WIDTH-1:0]      rdata_out
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wbin_reg;
    logic [AW:0]      wgray_reg;
    logic [AW:0]      rbin_reg;
    logic [AW:0]      rgray_reg;
    logic [AW:0]      rg_s1_reg;
    logic [AW:0]      rg_s2_reg;
    logic [AW:0]      wg_s1_reg;
    logic [AW:0]      wg_s2_reg;
    logic [AW:0]      wbin_next;
    logic [AW:0]      rbin_next;

    function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
        return b ^ (b >> 1);
    endfunction : bin2gray

    assign wready_out = (wgray_reg != {~rg_s2_reg[AW:AW-1], rg_s2_reg[AW-2:0]});
    assign rvalid_out = (rgray_reg != wg_s2_reg);
    assign wbin_next  = wbin_reg + (AW+1)'(1);
    assign rbin_next  = rbin_reg + (AW+1)'(1);
    assign rdata_out  = mem[rbin_reg[AW-1:0]];

    always_ff @(posedge wclk_in) begin
        if (wvalid_in && wready_out) begin
            mem[wbin_reg[AW-1:0]] <= wdata_in;
        end
    end

    always_ff @(posedge wclk_in) begin
        if (wrst_in) begin
            wbin_reg  <= '0;
            wgray_reg <= '0;
        end else if (wvalid_in && wready_out) begin
            wbin_reg  <= wbin_next;
            wgray_reg <= bin2gray(wbin_next);
        end
    end

    always_ff @(posedge wclk_in) begin
        if (wrst_in) begin
            rg_s1_reg <= '0;
            rg_s2_reg <= '0;
        end else begin
            rg_s1_reg <= rgray_reg;
            rg_s2_reg <= rg_s1_reg;
        end
    end

    always_ff @(posedge rclk_in) begin
        if (rrst_in) begin
            rbin_reg  <= '0;
            rgray_reg <= '0;
        end else if (rvalid_out && rready_in) begin
            rbin_reg  <= rbin_next;
            rgray_reg <= bin2gray(rbin_next);
        end
    end

    always_ff @(posedge rclk_in) begin
        if (rrst_in) begin
            wg_s1_reg <= '0;
            wg_s2_reg <= '0;
        end else begin
            wg_s1_reg <= wgray_reg;
            wg_s2_reg <= wg_s1_reg;
        end
    end

endmodule : vpc_fifo

// File: rtl/vpc_capture.sv
// Video capture input port: pixel sampling, sync decoding, FIFO and decoder control bus.
// How it works
// - RGB mode: bits 15..11 are red.
// - RGB mode: bits 10..5 are green.
// - RGB mode: bits 4..0 are blue.
// - YUV mode: bits 15..8 are luma.
// - YUV mode: bits 7..0 are chroma.
// - Any line sync edge starts a line.
// - Any field sync edge starts a field.
// - Line sync at field edge gives parity.
// - Pixel data sampled on pixel clock.
// - Drive control clock, two-way data line.
// - 8-bit mode ignores upper eight bits.
module vpc_capture (
    // System clock and reset.
    input  wire logic                 mclk_in,
    input  wire logic                 rst_in,
    // Video link from the decoder.
    input  wire logic                 pixel_clk_in,
    input  wire logic                 pixel_rst_in,
    input  wire logic [15:0]          video_pixel_in,
    input  wire logic                 line_sync_in,
    input  wire logic                 field_sync_in,
    // Capture configuration.
    input  wire vpc_pkg::vpc_mode_t   mode_in,
    input  wire logic                 capture_en_in,
    // Captured pixel stream, system clock.
    output logic                      pix_valid_out,
    input  wire logic                 pix_ready_in,
    output vpc_pkg::vpc_word_t        pix_word_out,
    output logic                      overflow_out,
    // Decoder control bus request.
    input  wire logic                 ctl_start_in,
    input  wire logic [7:0]           ctl_byte_in,
    output logic                      ctl_busy_out,
    output logic                      ctl_nack_out,
    // Decoder control bus pins.
    output logic                      decoder_ctl_scl_out,
    input  wire logic                 decoder_ctl_sda_in,
    output logic                      decoder_ctl_sda_out,
    output logic                      decoder_ctl_sda_oe_n_out
);

    // Pixel domain: inputs registered on the rising pixel clock edge.
    logic [15:0]        pix_s_reg;
    logic               line_s_reg;
    logic               field_s_reg;
    logic               line_p_reg;
    logic               field_p_reg;
    logic               line_flag_reg;
    logic               field_flag_reg;
    logic               odd_reg;
    logic               en_s1_reg;
    logic               en_s2_reg;
    logic               en_s3_reg;
    logic               en_reg;
    logic               line_edge;
    logic               field_edge;
    logic               w_ready;
    logic               w_valid;
    vpc_pkg::vpc_word_t w_word;
    vpc_pkg::vpc_word_t r_word;
    logic               ovf_tgl_reg;

    always_ff @(posedge pixel_clk_in) begin
        pix_s_reg   <= video_pixel_in;
        line_s_reg  <= line_sync_in;
        field_s_reg <= field_sync_in;
    end

    always_ff @(posedge pixel_clk_in) begin
        if (pixel_rst_in) begin
            line_p_reg  <= 1'b0;
            field_p_reg <= 1'b0;
        end else begin
            line_p_reg  <= line_s_reg;
            field_p_reg <= field_s_reg;
        end
    end

    // Capture enable crosses as a level; the second and third stages must agree.
    always_ff @(posedge pixel_clk_in) begin
        if (pixel_rst_in) begin
            en_s1_reg <= 1'b0;
            en_s2_reg <= 1'b0;
            en_s3_reg <= 1'b0;
            en_reg    <= 1'b0;
        end else begin
            en_s1_reg <= capture_en_in;
            en_s2_reg <= en_s1_reg;
            en_s3_reg <= en_s2_reg;
            if (en_s2_reg == en_s3_reg) begin
                en_reg <= en_s3_reg;
            end
        end
    end

    assign line_edge  = line_s_reg ^ line_p_reg;
    assign field_edge = field_s_reg ^ field_p_reg;

    // Boundary flags wait for the next stored pixel so none is lost to a stalled FIFO.
    // A stored word carries the edge itself, so a store clears the flag.
    always_ff @(posedge pixel_clk_in) begin
        if (pixel_rst_in) begin
            line_flag_reg  <= 1'b0;
            field_flag_reg <= 1'b0;
            odd_reg        <= 1'b0;
        end else begin
            if (field_edge) begin
                odd_reg <= line_s_reg;
            end
            if (w_valid && w_ready) begin
                line_flag_reg <= 1'b0;
            end else if (line_edge) begin
                line_flag_reg <= 1'b1;
            end
            if (w_valid && w_ready) begin
                field_flag_reg <= 1'b0;
            end else if (field_edge) begin
                field_flag_reg <= 1'b1;
            end
        end
    end

    always_comb begin
        w_word             = '0;
        w_word.line_start  = line_flag_reg | line_edge;
        w_word.field_start = field_flag_reg | field_edge;
        w_word.field_odd   = field_edge ? line_s_reg : odd_reg;
        if (mode_in == vpc_pkg::VPC_MODE_8BIT) begin
            w_word.data[vpc_pkg::CHROMA_HI:vpc_pkg::CHROMA_LO] =
                pix_s_reg[vpc_pkg::CHROMA_HI:vpc_pkg::CHROMA_LO];
        end else begin
            // Red, green and blue, or luma and chroma, keep their pin positions.
            w_word.data = pix_s_reg;
        end
    end

    assign w_valid = en_reg;

    // Dropped pixel events cross as a toggle.
    always_ff @(posedge pixel_clk_in) begin
        if (pixel_rst_in) begin
            ovf_tgl_reg <= 1'b0;
        end else if (w_valid && !w_ready) begin
            ovf_tgl_reg <= ~ovf_tgl_reg;
        end
    end

    vpc_fifo #(
        .WIDTH (vpc_pkg::WORD_W),
        .DEPTH (vpc_pkg::FIFO_DEPTH)
    ) u_fifo (
        .wclk_in    (pixel_clk_in),
        .wrst_in    (pixel_rst_in),
        .wvalid_in  (w_valid),
        .wready_out (w_ready),
        .wdata_in   (w_word),
        .rclk_in    (mclk_in),
        .rrst_in    (rst_in),
        .rvalid_out (pix_valid_out),
        .rready_in  (pix_ready_in),
        .rdata_out  (r_word)
    );

    assign pix_word_out = r_word;

    // System domain: sticky overflow from the toggle.
    logic ovf_s1_reg;
    logic ovf_s2_reg;
    logic ovf_s3_reg;

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            ovf_s1_reg   <= 1'b0;
            ovf_s2_reg   <= 1'b0;
            ovf_s3_reg   <= 1'b0;
            overflow_out <= 1'b0;
        end else begin
            ovf_s1_reg <= ovf_tgl_reg;
            ovf_s2_reg <= ovf_s1_reg;
            ovf_s3_reg <= ovf_s2_reg;
            if (ovf_s2_reg != ovf_s3_reg) begin
                overflow_out <= 1'b1;
            end
        end
    end

    // Decoder control bus: one byte per request, START, 8 bits, ACK, STOP.
    typedef enum logic [4:0] {
        VPC_ST_IDLE  = 5'h01,
        VPC_ST_START = 5'h02,
        VPC_ST_BIT   = 5'h04,
        VPC_ST_ACK   = 5'h08,
        VPC_ST_STOP  = 5'h10
    } vpc_ctl_st_t;

    vpc_ctl_st_t ctl_st_reg;
    logic [15:0] div_reg;
    logic        tick;
    logic        phase_reg;
    logic [2:0]  bit_reg;
    logic [7:0]  sh_reg;
    logic        sda_s1_reg;
    logic        sda_s2_reg;
    logic        sda_s3_reg;
    logic        sda_reg;
    logic        data_slot;

    assign tick = (div_reg == 16'(vpc_pkg::SCL_HALF - 1));
    // Data moves one cycle into a low clock half, never on a clock edge, so no false start or stop appears.
    assign data_slot = !phase_reg && (div_reg == 16'h0000);

    always_ff @(posedge mclk_in) begin
        if (rst_in || ctl_st_reg == VPC_ST_IDLE || tick) begin
            div_reg <= 16'h0000;
        end else begin
            div_reg <= div_reg + 16'h0001;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            sda_s1_reg <= 1'b1;
            sda_s2_reg <= 1'b1;
            sda_s3_reg <= 1'b1;
            sda_reg    <= 1'b1;
        end else begin
            sda_s1_reg <= decoder_ctl_sda_in;
            sda_s2_reg <= sda_s1_reg;
            sda_s3_reg <= sda_s2_reg;
            if (sda_s2_reg == sda_s3_reg) begin
                sda_reg <= sda_s3_reg;
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            ctl_st_reg               <= VPC_ST_IDLE;
            phase_reg                <= 1'b0;
            bit_reg                  <= 3'h0;
            sh_reg                   <= 8'h00;
            ctl_nack_out             <= 1'b0;
            decoder_ctl_scl_out      <= 1'b1;
            decoder_ctl_sda_oe_n_out <= 1'b1;
        end else begin
            case (ctl_st_reg)
                VPC_ST_IDLE: begin
                    decoder_ctl_scl_out      <= 1'b1;
                    decoder_ctl_sda_oe_n_out <= 1'b1;
                    if (ctl_start_in) begin
                        sh_reg                   <= ctl_byte_in;
                        ctl_nack_out             <= 1'b0;
                        decoder_ctl_sda_oe_n_out <= 1'b0;
                        ctl_st_reg               <= VPC_ST_START;
                    end
                end
                VPC_ST_START: begin
                    if (tick) begin
                        decoder_ctl_scl_out <= 1'b0;
                        phase_reg           <= 1'b0;
                        bit_reg             <= 3'h7;
                        ctl_st_reg          <= VPC_ST_BIT;
                    end
                end
                VPC_ST_BIT: begin
                    if (data_slot) begin
                        decoder_ctl_sda_oe_n_out <= sh_reg[bit_reg];
                    end
                    if (tick) begin
                        phase_reg <= ~phase_reg;
                        if (!phase_reg) begin
                            decoder_ctl_scl_out <= 1'b1;
                        end else begin
                            decoder_ctl_scl_out <= 1'b0;
                            bit_reg             <= bit_reg - 3'h1;
                            if (bit_reg == 3'h0) begin
                                ctl_st_reg <= VPC_ST_ACK;
                            end
                        end
                    end
                end
                VPC_ST_ACK: begin
                    if (data_slot) begin
                        decoder_ctl_sda_oe_n_out <= 1'b1;
                    end
                    if (tick) begin
                        phase_reg <= ~phase_reg;
                        if (!phase_reg) begin
                            decoder_ctl_scl_out <= 1'b1;
                        end else begin
                            ctl_nack_out        <= sda_reg;
                            decoder_ctl_scl_out <= 1'b0;
                            ctl_st_reg          <= VPC_ST_STOP;
                        end
                    end
                end
                VPC_ST_STOP: begin
                    if (data_slot) begin
                        decoder_ctl_sda_oe_n_out <= 1'b0;
                    end
                    if (tick) begin
                        phase_reg <= ~phase_reg;
                        if (!phase_reg) begin
                            decoder_ctl_scl_out <= 1'b1;
                        end else begin
                            decoder_ctl_sda_oe_n_out <= 1'b1;
                            ctl_st_reg               <= VPC_ST_IDLE;
                        end
                    end
                end
                default: begin
                    ctl_st_reg <= VPC_ST_IDLE;
                end
            endcase
        end
    end

    // The line is open drain: only a low is ever driven.
    assign decoder_ctl_sda_out = 1'b0;
    assign ctl_busy_out        = (ctl_st_reg != VPC_ST_IDLE);

    // Checks.
    property p_line_edge;
        @(posedge pixel_clk_in) disable iff (pixel_rst_in)
        (line_s_reg != $past(line_s_reg)) |-> w_word.line_start;
    endproperty
    a_line_edge: assert property (p_line_edge) else $error("line edge not marked");

    property p_field_edge;
        @(posedge pixel_clk_in) disable iff (pixel_rst_in)
        (field_s_reg != $past(field_s_reg)) |-> w_word.field_start;
    endproperty
    a_field_edge: assert property (p_field_edge) else $error("field edge not marked");

    property p_parity;
        @(posedge pixel_clk_in) disable iff (pixel_rst_in)
        field_edge |=> (odd_reg == $past(line_s_reg));
    endproperty
    a_parity: assert property (p_parity) else $error("field parity wrong");

    property p_rgb;
        @(posedge pixel_clk_in) disable iff (pixel_rst_in)
        (mode_in == vpc_pkg::VPC_MODE_RGB565) |-> (w_word.data == pix_s_reg);
    endproperty
    a_rgb: assert property (p_rgb) else $error("rgb fields misplaced");

    property p_yuv;
        @(posedge pixel_clk_in) disable iff (pixel_rst_in)
        (mode_in == vpc_pkg::VPC_MODE_YUV422) |-> (w_word.data[15:8] == pix_s_reg[15:8]);
    endproperty
    a_yuv: assert property (p_yuv) else $error("luma misplaced");

    property p_8bit;
        @(posedge pixel_clk_in) disable iff (pixel_rst_in)
        (mode_in == vpc_pkg::VPC_MODE_8BIT) |-> (w_word.data[15:8] == 8'h00);
    endproperty
    a_8bit: assert property (p_8bit) else $error("upper byte not ignored");

    property p_sample;
        @(posedge pixel_clk_in) disable iff (pixel_rst_in)
        1'b1 |=> (pix_s_reg == $past(video_pixel_in));
    endproperty
    a_sample: assert property (p_sample) else $error("pixel not sampled");

    sequence s_start_req;
        (ctl_st_reg == VPC_ST_IDLE) && ctl_start_in;
    endsequence
    property p_ctl_start;
        @(posedge mclk_in) disable iff (rst_in)
        s_start_req |=> (!decoder_ctl_sda_oe_n_out && decoder_ctl_scl_out);
    endproperty
    a_ctl_start: assert property (p_ctl_start) else $error("start condition wrong");

endmodule : vpc_capture

// File: tb/vpc_decoder_model.sv
// Behavioural model of the video decoder that feeds the capture port.
module vpc_decoder_model (
    // Video link.
    output logic        pixel_clk_out,
    output logic [15:0] pixel_out,
    output logic        line_sync_out,
    output logic        field_sync_out,
    // Control bus pins of the capture port.
    input  wire logic   scl_in,
    input  wire logic   sda_drv_in,
    input  wire logic   sda_oe_n_in,
    output logic        sda_wire_out
);
    timeunit 1ns;
    timeprecision 100ps;

    logic       ack_en;
    logic       slave_low;
    logic       stop_seen;
    logic [7:0] rx_byte;
    int         rx_cnt;

    initial begin
        pixel_clk_out = 1'b0;
        pixel_out = 16'h0000;
        line_sync_out = 1'b0;
        field_sync_out = 1'b0;
        ack_en = 1'b1;
        slave_low = 1'b0;
        stop_seen = 1'b0;
        rx_byte = 8'h00;
        rx_cnt = 9;
    end

    // The pull-up wins unless some party pulls the wire low.
    assign sda_wire_out = !((!sda_oe_n_in && !sda_drv_in) || slave_low);

    // The clock stands still between bursts, so words are taken only while pclk pulses it.
    task automatic pclk(input int n);
        repeat (n) begin
            #62.5 pixel_clk_out = 1'b1;
            #62.5 pixel_clk_out = 1'b0;
        end
    endtask : pclk

    // Data changes with the clock low; after the hold the bus shows the inverse.
    task automatic send(input logic [15:0] d, input logic ls, input logic fs);
        pixel_out = d;
        line_sync_out = ls;
        field_sync_out = fs;
        pclk(1);
        pixel_out = ~d;
    endtask : send

    // A fall of the data line with the clock high is a start condition.
    always @(negedge sda_wire_out) begin
        if (scl_in === 1'b1) begin
            rx_cnt = 0;
            stop_seen = 1'b0;
        end
    end

    // A rise of the data line with the clock high is a stop condition.
    always @(posedge sda_wire_out) begin
        if (scl_in === 1'b1) begin
            stop_seen = 1'b1;
        end
    end

    always @(posedge scl_in) begin
        if (rx_cnt < 8) begin
            rx_byte = {rx_byte[6:0], sda_wire_out};
        end
        rx_cnt++;
    end

    always @(negedge scl_in) begin
        slave_low = ack_en && rx_cnt == 8;
    end
endmodule : vpc_decoder_model

// File: tb/vpc_capture_tb.sv
// Self-checking testbench of the video capture port.
module vpc_capture_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic               mclk_in, rst_in, pixel_rst_in, capture_en_in, pix_ready_in, ctl_start_in;
    logic [7:0]         ctl_byte_in;
    vpc_pkg::vpc_mode_t mode_in;
    logic               pclk, lsync, fsync, sda, scl, sda_drv, sda_oe_n;
    logic [15:0]        pix;
    logic               pix_valid_out, overflow_out, ctl_busy_out, ctl_nack_out;
    vpc_pkg::vpc_word_t pix_word_out;
    vpc_pkg::vpc_word_t stim[$];
    vpc_pkg::vpc_word_t expq[$];
    int                 miscompares, num_checks, cyc;

    vpc_capture u_vpc_capture (
        .mclk_in(mclk_in), .rst_in(rst_in), .pixel_clk_in(pclk), .pixel_rst_in(pixel_rst_in),
        .video_pixel_in(pix), .line_sync_in(lsync), .field_sync_in(fsync), .mode_in(mode_in),
        .capture_en_in(capture_en_in), .pix_valid_out(pix_valid_out), .pix_ready_in(pix_ready_in),
        .pix_word_out(pix_word_out), .overflow_out(overflow_out), .ctl_start_in(ctl_start_in),
        .ctl_byte_in(ctl_byte_in), .ctl_busy_out(ctl_busy_out), .ctl_nack_out(ctl_nack_out),
        .decoder_ctl_scl_out(scl), .decoder_ctl_sda_in(sda), .decoder_ctl_sda_out(sda_drv),
        .decoder_ctl_sda_oe_n_out(sda_oe_n));

    vpc_decoder_model u_vpc_decoder_model (
        .pixel_clk_out(pclk), .pixel_out(pix), .line_sync_out(lsync), .field_sync_out(fsync),
        .scl_in(scl), .sda_drv_in(sda_drv), .sda_oe_n_in(sda_oe_n), .sda_wire_out(sda));

    initial begin
        mclk_in = 1'b0;
        forever #10 mclk_in = ~mclk_in;
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop

    // Two control transfers take about 11000 cycles; the rest is small.
    always @(posedge mclk_in) begin
        cyc++;
        if (cyc == 60000) begin
            miscompares++;
            report_and_stop();
        end
    end

    task automatic chk1(input logic got, input logic exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s got %b", $time, msg, got);
        end
    endtask : chk1

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk16

    task automatic add(input logic [15:0] d, e, input logic ls, fs, lsf, fsf, odd);
        stim.push_back({d, ls, fs, 1'b0});
        expq.push_back({e, lsf, fsf, odd});
    endtask : add

    task automatic pop(output vpc_pkg::vpc_word_t w);
        int n;
        n = 0;
        do begin
            @(posedge mclk_in);
            n++;
        end while (pix_valid_out !== 1'b1 && n < 300);
        w = pix_word_out;
        pix_ready_in <= 1'b1;
        @(posedge mclk_in);
        pix_ready_in <= 1'b0;
    endtask : pop

    // Leftover flush words sit ahead of a burst, so the first expected word is searched for.
    task automatic expect_q();
        vpc_pkg::vpc_word_t w;
        int k;
        k = 0;
        pop(w);
        while (w.data !== expq[0].data && k < 6) begin
            pop(w);
            k++;
        end
        foreach (expq[i]) begin
            if (i > 0) pop(w);
            chk16(w.data, expq[i].data, "pixel data");
            chk1(w.line_start, expq[i].line_start, "line start");
            chk1(w.field_start, expq[i].field_start, "field start");
            if (expq[i].field_start) chk1(w.field_odd, expq[i].field_odd, "field parity");
        end
    endtask : expect_q

    task automatic run();
        fork
            begin
                foreach (stim[i]) u_vpc_decoder_model.send(stim[i].data, stim[i].line_start, stim[i].field_start);
                u_vpc_decoder_model.pclk(3);
            end
            expect_q();
        join
        stim.delete();
        expq.delete();
    endtask : run

    task automatic drain();
        repeat (40) begin
            @(posedge mclk_in);
            pix_ready_in <= pix_valid_out;
        end
        @(posedge mclk_in);
        pix_ready_in <= 1'b0;
    endtask : drain

    task automatic t_reset();
        rst_in <= 1'b1;
        pixel_rst_in <= 1'b1;
        fork
            repeat (3) @(posedge mclk_in);
            u_vpc_decoder_model.pclk(3);
        join
        #1;
        chk1(pix_valid_out, 1'b0, "valid in reset");
        chk1(overflow_out, 1'b0, "overflow in reset");
        chk1(scl, 1'b1, "scl in reset");
        chk1(sda_oe_n, 1'b1, "sda in reset");
        chk1(ctl_busy_out, 1'b0, "busy in reset");
        chk1(ctl_nack_out, 1'b0, "nack in reset");
        @(posedge mclk_in);
        rst_in <= 1'b0;
        pixel_rst_in <= 1'b0;
        capture_en_in <= 1'b1;
        u_vpc_decoder_model.pclk(6);
        drain();
    endtask : t_reset

    task automatic t_rgb();
        add(16'hF800, 16'hF800, 0, 0, 0, 0, 0);
        add(16'h07E0, 16'h07E0, 0, 0, 0, 0, 0);
        add(16'h001F, 16'h001F, 0, 0, 0, 0, 0);
        add(16'hA5C3, {5'h14, 6'h2E, 5'h03}, 0, 0, 0, 0, 0);
        run();
    endtask : t_rgb

    task automatic t_sync();
        add(16'h1111, 16'h1111, 0, 0, 0, 0, 0);
        add(16'h2222, 16'h2222, 1, 0, 1, 0, 0);
        add(16'h3333, 16'h3333, 1, 0, 0, 0, 0);
        add(16'h4444, 16'h4444, 0, 0, 1, 0, 0);
        add(16'h5555, 16'h5555, 0, 1, 0, 1, 0);
        add(16'h6666, 16'h6666, 1, 1, 1, 0, 0);
        add(16'h7777, 16'h7777, 1, 0, 0, 1, 1);
        add(16'h9999, 16'h9999, 0, 0, 1, 0, 0);
        run();
    endtask : t_sync

    task automatic t_yuv();
        @(posedge mclk_in);
        mode_in <= vpc_pkg::VPC_MODE_YUV422;
        add({8'h80, 8'h10}, {8'h80, 8'h10}, 0, 0, 0, 0, 0);
        add({8'h81, 8'hF0}, {8'h81, 8'hF0}, 0, 0, 0, 0, 0);
        run();
    endtask : t_yuv

    task automatic t_8bit();
        @(posedge mclk_in);
        mode_in <= vpc_pkg::VPC_MODE_8BIT;
        add(16'hABCD, 16'h00CD, 0, 0, 0, 0, 0);
        add(16'hFF3C, 16'h003C, 0, 0, 0, 0, 0);
        run();
    endtask : t_8bit

    // The consumer stalls while ten words arrive; the eight-word buffer must refuse the surplus.
    task automatic t_overflow();
        drain();
        chk1(overflow_out, 1'b0, "overflow early");
        for (int i = 0; i < 10; i++) begin
            u_vpc_decoder_model.send(16'h0040 + 16'(i), 1'b0, 1'b0);
            if (i < 6) add(16'h0040 + 16'(i), 16'h0040 + 16'(i), 0, 0, 0, 0, 0);
        end
        u_vpc_decoder_model.pclk(3);
        repeat (8) @(posedge mclk_in);
        chk1(overflow_out, 1'b1, "overflow");
        expect_q();
        expq.delete();
        drain();
    endtask : t_overflow

    // A second start in mid-transfer must be ignored.
    task automatic ctl_xfer(input logic [7:0] b, input logic ack);
        int n;
        u_vpc_decoder_model.ack_en = ack;
        @(posedge mclk_in);
        ctl_byte_in <= b;
        ctl_start_in <= 1'b1;
        @(posedge mclk_in);
        ctl_start_in <= 1'b0;
        #1 chk1(ctl_busy_out, 1'b1, "busy");
        repeat (100) @(posedge mclk_in);
        ctl_byte_in <= ~b;
        ctl_start_in <= 1'b1;
        @(posedge mclk_in);
        ctl_start_in <= 1'b0;
        n = 0;
        while (ctl_busy_out === 1'b1 && n < 8000) begin
            @(posedge mclk_in);
            n++;
        end
        repeat (5) @(posedge mclk_in);
        chk1(ctl_busy_out, 1'b0, "busy after");
        chk16({8'h00, u_vpc_decoder_model.rx_byte}, {8'h00, b}, "control byte");
        // Eight data clocks, one acknowledge clock and the high clock of the stop.
        chk1(u_vpc_decoder_model.rx_cnt == 10, 1'b1, "clock count");
        chk1(u_vpc_decoder_model.stop_seen, 1'b1, "stop condition");
        chk1(ctl_nack_out, !ack, "nack");
        chk1(scl, 1'b1, "scl idle");
        chk1(sda_oe_n, 1'b1, "sda released");
    endtask : ctl_xfer

    task automatic t_ctl_ack();
        ctl_xfer(8'hA6, 1'b1);
    endtask : t_ctl_ack

    task automatic t_ctl_nack();
        ctl_xfer(8'h59, 1'b0);
    endtask : t_ctl_nack

    initial begin
        rst_in = 1'b1;
        pixel_rst_in = 1'b1;
        capture_en_in = 1'b0;
        pix_ready_in = 1'b0;
        ctl_start_in = 1'b0;
        ctl_byte_in = 8'h00;
        mode_in = vpc_pkg::VPC_MODE_RGB565;
        t_reset();
        t_rgb();
        t_sync();
        t_yuv();
        t_8bit();
        t_overflow();
        t_ctl_ack();
        t_ctl_nack();
        report_and_stop();
    end
endmodule : vpc_capture_tb
